// [core/loops_map.svh]
`ifndef LOOPS_MAP_SVH
`define LOOPS_MAP_SVH
// Contract
// - Gate bit freezes both loops until carrier.
// - Pre-sync frequency gain K, 2K, 3K, 4K.
// - Post-sync frequency gain: same, or K/2.
// - Frequency saturation: off, BW/8, BW/4, BW/2.
// - Pre-sync integral gain KI to 4KI.
// - Pre-sync proportional gain KP to 4KP.
// - Post-sync integral gain: same, or KI/2.
// - Post-sync proportional gain: same, or KP.
// - Rate saturation: off, 3.125, 6.25, 12.5 percent.
// ----------------------------------------------------------
// Register map
// ----------------------------------------------------------
`define FREQ_CFG_ADDR 6'h19
`define BITSYNC_CFG_ADDR 6'h1a
`define FREQ_CFG_RESET 8'h36
`define BITSYNC_CFG_RESET 8'h6c
`define FREQ_CFG_WMASK 8'h3f
// ----------------------------------------------------------
// Gain and limit encodings
// ----------------------------------------------------------
`define GAIN_HALF_UNIT 4'h1
`define POST_KP_HALF 4'h2
`define FREQ_LIM_BASE 3'h3
`define RATE_LIM_BASE 3'h6
`endif

// [core/loops_pkg.sv]
package loops_pkg;

  typedef struct packed {
    logic [1:0] unused;
    logic freeze_gate;
    logic [1:0] gain_pre;
    logic gain_post;
    logic [1:0] sat;
  } freq_cfg_t;

  typedef struct packed {
    logic [1:0] ki_pre;
    logic [1:0] kp_pre;
    logic ki_post;
    logic kp_post;
    logic [1:0] sat;
  } bitsync_cfg_t;

  typedef enum logic {
    SEARCH,
    LOCKED
  } sync_state_t;

endpackage : loops_pkg

// [core/freq_offset_and_bit_sync_loops.sv]
`timescale 1ns/1ps
`include "loops_map.svh"
module freq_offset_and_bit_sync_loops #(
  parameter int EW = 8,
  parameter int AW = 16,
  parameter int GAIN_SHIFT = 3,
  parameter logic [AW-1:0] FREQ_FULL = 16'h3fff,
  parameter logic [AW-1:0] RATE_NOM = 16'h2000
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Register port
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [5:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  // Receive control
  input wire logic rx_start_i,
  input wire logic sync_detected_i,
  input wire logic carrier_sense_i,
  // Error samples
  input wire logic err_valid_i,
  input wire logic signed [EW-1:0] freq_err_i,
  input wire logic signed [EW-1:0] timing_err_i,
  // Loop outputs
  output logic signed [AW-1:0] freq_offset_o,
  output logic signed [AW-1:0] rate_offset_o,
  output logic [AW-1:0] clk_step_o,
  output logic loops_frozen_o,
  output logic post_sync_o
);

  localparam int PW = EW + 5;

  // ----------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------
  // Gains are kept in half units so that K/2 stays exact.
  function automatic logic [3:0] gain_half(
    input logic [1:0] code
  );
    gain_half = 4'({code, 1'b0}) + 4'h2;
  endfunction : gain_half

  function automatic logic [AW-1:0] lim_sel(
    input logic [1:0] code,
    input logic [AW-1:0] full,
    input logic [2:0] base
  );
    logic [2:0] sh;
    sh = base - {1'b0, code};
    if (code == 2'h0)
    begin
      lim_sel = '0;
    end
    else
    begin
      lim_sel = full >> sh;
    end
  endfunction : lim_sel

  function automatic logic signed [AW-1:0] sat(
    input logic signed [AW:0] v,
    input logic [AW-1:0] lim
  );
    logic signed [AW:0] hi;
    logic signed [AW:0] lo;
    hi = $signed({1'b0, lim});
    lo = -hi;
    if (v > hi)
    begin
      sat = hi[AW-1:0];
    end
    else if (v < -hi)
    begin
      sat = lo[AW-1:0];
    end
    else
    begin
      sat = v[AW-1:0];
    end
  endfunction : sat

  function automatic logic signed [AW:0] scale(
    input logic signed [EW-1:0] err,
    input logic [3:0] g
  );
    logic signed [PW-1:0] p;
    logic signed [AW:0] e;
    p = err * $signed({1'b0, g});
    e = {{(AW + 1 - PW){p[PW-1]}}, p};
    scale = e >>> (GAIN_SHIFT + 1);
  endfunction : scale

  // ----------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------
  loops_pkg::freq_cfg_t freq_cfg_reg;
  loops_pkg::bitsync_cfg_t bs_cfg_reg;
  logic [7:0] rdata_reg;

  wire hit_freq = reg_addr_i == `FREQ_CFG_ADDR;
  wire hit_bs = reg_addr_i == `BITSYNC_CFG_ADDR;
  wire [7:0] rdata_next = hit_freq ? freq_cfg_reg :
    hit_bs ? bs_cfg_reg : 8'h00;

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      freq_cfg_reg <= `FREQ_CFG_RESET;
      bs_cfg_reg <= `BITSYNC_CFG_RESET;
    end
    else if (reg_wr_i)
    begin
      // Unused high bits of the frequency register stay zero.
      if (hit_freq)
      begin
        freq_cfg_reg <= reg_wdata_i & `FREQ_CFG_WMASK;
      end
      if (hit_bs)
      begin
        bs_cfg_reg <= reg_wdata_i;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rdata_reg <= 8'h00;
    end
    else if (reg_rd_i)
    begin
      rdata_reg <= rdata_next;
    end
  end

  // ----------------------------------------------------------
  // Sync tracking and carrier gate
  // ----------------------------------------------------------
  loops_pkg::sync_state_t state_reg;
  loops_pkg::sync_state_t state_next;
  logic cs_seen_reg;

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      loops_pkg::SEARCH:
      begin
        if (sync_detected_i && !rx_start_i)
        begin
          state_next = loops_pkg::LOCKED;
        end
      end
      loops_pkg::LOCKED:
      begin
        if (rx_start_i)
        begin
          state_next = loops_pkg::SEARCH;
        end
      end
      default:
      begin
        state_next = loops_pkg::SEARCH;
      end
    endcase
  end

  // A new search forgets carrier, so each frame is gated afresh.
  wire cs_seen_next = rx_start_i ? 1'b0 : (cs_seen_reg | carrier_sense_i);
  wire frozen = freq_cfg_reg.freeze_gate & ~cs_seen_reg;
  wire post = state_reg == loops_pkg::LOCKED;

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_reg <= loops_pkg::SEARCH;
      cs_seen_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      cs_seen_reg <= cs_seen_next;
    end
  end

  // ----------------------------------------------------------
  // Gain selection
  // ----------------------------------------------------------
  wire [3:0] fk_pre = gain_half(freq_cfg_reg.gain_pre);
  wire [3:0] fk = (post && freq_cfg_reg.gain_post) ?
    `GAIN_HALF_UNIT : fk_pre;
  wire [3:0] ki_pre = gain_half(bs_cfg_reg.ki_pre);
  wire [3:0] ki = (post && bs_cfg_reg.ki_post) ?
    `GAIN_HALF_UNIT : ki_pre;
  wire [3:0] kp_pre = gain_half(bs_cfg_reg.kp_pre);
  wire [3:0] kp = (post && bs_cfg_reg.kp_post) ?
    `POST_KP_HALF : kp_pre;

  // ----------------------------------------------------------
  // Saturation limits
  // ----------------------------------------------------------
  // Limit 2 of the frequency loop is taken as a quarter bandwidth.
  wire [AW-1:0] freq_lim = lim_sel(freq_cfg_reg.sat,
    FREQ_FULL, `FREQ_LIM_BASE);
  wire [AW-1:0] rate_lim = lim_sel(bs_cfg_reg.sat,
    RATE_NOM, `RATE_LIM_BASE);

  // ----------------------------------------------------------
  // Loop arithmetic
  // ----------------------------------------------------------
  logic signed [AW-1:0] freq_acc_reg;
  logic signed [AW-1:0] rate_acc_reg;
  logic signed [AW-1:0] prop_reg;
  logic [AW-1:0] step_reg;
  logic frozen_reg;
  logic post_reg;

  wire step_en = err_valid_i & ~frozen;
  wire signed [AW:0] freq_sum = {freq_acc_reg[AW-1], freq_acc_reg}
    + scale(freq_err_i, fk);
  wire signed [AW:0] rate_sum = {rate_acc_reg[AW-1], rate_acc_reg}
    + scale(timing_err_i, ki);
  wire signed [AW:0] prop_full = scale(timing_err_i, kp);
  // Saturation applies every cycle, so a tighter limit takes hold at once.
  wire signed [AW-1:0] freq_next = step_en ?
    sat(freq_sum, freq_lim) :
    sat({freq_acc_reg[AW-1], freq_acc_reg}, freq_lim);
  wire signed [AW-1:0] rate_next = step_en ?
    sat(rate_sum, rate_lim) :
    sat({rate_acc_reg[AW-1], rate_acc_reg}, rate_lim);
  wire signed [AW-1:0] prop_next = step_en ? prop_full[AW-1:0] : '0;
  wire [AW-1:0] step_next = RATE_NOM + rate_next + prop_next;

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      freq_acc_reg <= '0;
      rate_acc_reg <= '0;
      prop_reg <= '0;
      step_reg <= RATE_NOM;
    end
    else
    begin
      freq_acc_reg <= freq_next;
      rate_acc_reg <= rate_next;
      prop_reg <= prop_next;
      step_reg <= step_next;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      frozen_reg <= 1'b1;
      post_reg <= 1'b0;
    end
    else
    begin
      frozen_reg <= frozen;
      post_reg <= post;
    end
  end

  // ----------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------
  assign reg_rdata_o = rdata_reg;
  assign freq_offset_o = freq_acc_reg;
  assign rate_offset_o = rate_acc_reg;
  assign clk_step_o = step_reg;
  assign loops_frozen_o = frozen_reg;
  assign post_sync_o = post_reg;

endmodule : freq_offset_and_bit_sync_loops

// [sim/loops_chk.sv]
`timescale 1ns/1ps
module loops_chk #(
  parameter int AW = 16,
  parameter logic [AW-1:0] FREQ_FULL = 16'h3fff,
  parameter logic [AW-1:0] RATE_NOM = 16'h2000
) (
  // Inputs
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [5:0] reg_addr_i,
  input wire logic rx_start_i,
  input wire logic sync_detected_i,
  input wire logic err_valid_i,
  // Outputs
  input wire logic [7:0] reg_rdata_o,
  input wire logic signed [AW-1:0] freq_offset_o,
  input wire logic signed [AW-1:0] rate_offset_o,
  input wire logic [AW-1:0] clk_step_o,
  input wire logic loops_frozen_o,
  input wire logic post_sync_o
);
  localparam logic signed [AW-1:0] RATE_LIM = RATE_NOM >> 3;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // ----
  // Checks
  // ----
  // Writes and searches are kept out of the window; a write may move the offsets through a new limit, a search cannot without a sample.
  sequence idle_s;
    !reg_wr_i && !rx_start_i ##1 !reg_wr_i && !rx_start_i && !err_valid_i;
  endsequence
  sequence lock_s;
    sync_detected_i && !rx_start_i ##1 !rx_start_i;
  endsequence
  hold_idle_a: assert property (idle_s |=> $stable(freq_offset_o))
    else $error("offset moved without sample");
  step_settle_a: assert property (idle_s |=> clk_step_o == AW'(RATE_NOM + rate_offset_o))
    else $error("step kept a stale term");
  frozen_hold_a: assert property (loops_frozen_o && !$past(reg_wr_i)
    && !$past(reg_wr_i, 2) && !$past(rx_start_i) |-> $stable(rate_offset_o))
    else $error("frozen loop moved");
  lock_after_a: assert property (lock_s |=> post_sync_o)
    else $error("sync not taken");
  search_revert_a: assert property (rx_start_i |=> ##1 !post_sync_o)
    else $error("search kept lock");
  freq_sat_a: assert property (freq_offset_o <= $signed(FREQ_FULL)
    && freq_offset_o >= -$signed(FREQ_FULL))
    else $error("frequency past limit");
  rate_sat_a: assert property (rate_offset_o <= RATE_LIM && rate_offset_o >= -RATE_LIM)
    else $error("rate past limit");
  rdata_hold_a: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
    else $error("read data moved");
  unmapped_rd_a: assert property (reg_rd_i && reg_addr_i != 6'h19
    && reg_addr_i != 6'h1a |=> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  unused_bits_a: assert property (reg_rd_i && reg_addr_i == 6'h19 |=> reg_rdata_o[7:6] == 2'h0)
    else $error("unused bits set");
endmodule : loops_chk

// [sim/freq_offset_and_bit_sync_loops_bench.sv]
`timescale 1ns/1ps
`include "loops_map.svh"
module freq_offset_and_bit_sync_loops_bench;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic reg_wr_i = 1'b0, reg_rd_i = 1'b0, rx_start_i = 1'b0, sync_detected_i = 1'b0;
  logic carrier_sense_i = 1'b0, err_valid_i = 1'b0, loops_frozen_o, post_sync_o;
  logic [5:0] reg_addr_i = 6'h00;
  logic [7:0] reg_wdata_i = 8'h00, reg_rdata_o, rv;
  logic signed [7:0] freq_err_i = 8'sh00, timing_err_i = 8'sh00;
  logic signed [15:0] freq_offset_o, rate_offset_o, fe, re;
  logic [15:0] clk_step_o;
  int err_count = 0, comparisons = 0;
  loops_pkg::freq_cfg_t fc;
  loops_pkg::bitsync_cfg_t bc;
  always #20 clk_i = ~clk_i;
  freq_offset_and_bit_sync_loops u_dut (.*);
  // ----
  // Helpers
  // ----
  task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask : wr
  task rd(input logic [5:0] a);
    @(posedge clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1 rv = reg_rdata_o;
  endtask : rd
  // Holding the strobe for n cycles feeds n samples back to back.
  task samp(input int n, input logic signed [7:0] f, input logic signed [7:0] t);
    @(posedge clk_i);
    err_valid_i <= 1'b1;
    freq_err_i <= f;
    timing_err_i <= t;
    repeat (n) @(posedge clk_i);
    err_valid_i <= 1'b0;
    @(posedge clk_i);
    #1;
  endtask : samp
  // ----
  // Scenarios
  // ----
  task t_regs;
    rd(`FREQ_CFG_ADDR);
    check("freq cfg", rv, `FREQ_CFG_RESET);
    rd(`BITSYNC_CFG_ADDR);
    check("bitsync cfg", rv, `BITSYNC_CFG_RESET);
    rd(6'h3f);
    check("unmapped", rv, 8'h00);
    wr(`FREQ_CFG_ADDR, 8'hff);
    rd(`FREQ_CFG_ADDR);
    check("unused bits", rv, `FREQ_CFG_WMASK);
    wr(`FREQ_CFG_ADDR, `FREQ_CFG_RESET);
  endtask : t_regs
  task t_freeze;
    samp(4, 8'sd16, 8'sd16);
    check("frozen", loops_frozen_o, 1'b1);
    check("frozen freq", freq_offset_o, 16'h0000);
    @(posedge clk_i);
    carrier_sense_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    samp(1, 8'sd16, 8'sd16);
    check("thawed", loops_frozen_o, 1'b0);
    check("freq step", freq_offset_o, 16'h0006);
    check("rate off", rate_offset_o, 16'h0000);
    fe = 16'sh0006;
    re = 16'sh0000;
  endtask : t_freeze
  task t_gain;
    for (int c = 0; c < 4; c++)
    begin
      fc = '{2'h0, 1'b0, c[1:0], 1'b1, 2'h3};
      bc = '{c[1:0], c[1:0], 1'b1, 1'b1, 2'h3};
      wr(`FREQ_CFG_ADDR, fc);
      wr(`BITSYNC_CFG_ADDR, bc);
      samp(1, 8'sd16, 8'sd16);
      fe += 16'(2 * (c + 1));
      re += 16'(2 * (c + 1));
      check("freq gain", freq_offset_o, fe);
      check("rate gain", rate_offset_o, re);
    end
    rd(`BITSYNC_CFG_ADDR);
    check("bitsync rw", rv, 8'hff);
  endtask : t_gain
  task t_sync;
    @(posedge clk_i);
    sync_detected_i <= 1'b1;
    @(posedge clk_i);
    sync_detected_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    #1 check("locked", post_sync_o, 1'b1);
    // A timing-only sample shows the post-sync proportional term for one cycle.
    @(posedge clk_i);
    err_valid_i <= 1'b1;
    freq_err_i <= 8'sh00;
    timing_err_i <= 8'sd16;
    @(posedge clk_i);
    err_valid_i <= 1'b0;
    #1 check("post kp", clk_step_o, 16'h2000 + 16'(re + 16'sd1) + 16'h0002);
    re += 16'sd1;
    samp(1, 8'sd16, 8'sd16);
    check("freq half", freq_offset_o, fe + 16'sd1);
    check("rate half", rate_offset_o, re + 16'sd1);
    fc.gain_post = 1'b0;
    bc.ki_post = 1'b0;
    wr(`FREQ_CFG_ADDR, fc);
    wr(`BITSYNC_CFG_ADDR, bc);
    samp(1, 8'sd16, 8'sd16);
    fe += 16'sd9;
    re += 16'sd9;
    check("freq same", freq_offset_o, fe);
    check("rate same", rate_offset_o, re);
    fc.gain_post = 1'b1;
    bc.ki_post = 1'b1;
    wr(`FREQ_CFG_ADDR, fc);
    wr(`BITSYNC_CFG_ADDR, bc);
    @(posedge clk_i);
    rx_start_i <= 1'b1;
    @(posedge clk_i);
    rx_start_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    #1 check("searching", post_sync_o, 1'b0);
    samp(1, -8'sd16, -8'sd16);
    check("freq pre", freq_offset_o, fe - 16'sd8);
  endtask : t_sync
  task t_sat;
    wr(`FREQ_CFG_ADDR, 8'h19);
    wr(`BITSYNC_CFG_ADDR, 8'hc1);
    samp(80, 8'sd127, 8'sd127);
    check("freq top", freq_offset_o, 16'h0fff);
    check("rate top", rate_offset_o, 16'h0100);
    // Full swing across the frequency limit takes 128 samples of 64.
    samp(160, -8'sd128, -8'sd128);
    check("freq bottom", freq_offset_o, 16'hf001);
    check("rate bottom", rate_offset_o, 16'hff00);
    wr(`FREQ_CFG_ADDR, 8'h18);
    wr(`BITSYNC_CFG_ADDR, 8'hc0);
    repeat (2) @(posedge clk_i);
    #1 check("freq off", freq_offset_o, 16'h0000);
    check("rate off", rate_offset_o, 16'h0000);
  endtask : t_sat
  task final_report;
    $display("comparisons %0d errors %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : final_report
  // The whole run needs well under a thousand cycles.
  initial
  begin
    repeat (5000) @(posedge clk_i);
    err_count++;
    final_report();
  end
  initial
  begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_freeze();
    t_gain();
    t_sync();
    t_sat();
    final_report();
  end
endmodule : freq_offset_and_bit_sync_loops_bench
bind freq_offset_and_bit_sync_loops loops_chk #(.AW(AW), .FREQ_FULL(FREQ_FULL),
  .RATE_NOM(RATE_NOM)) u_chk (.*);
